// [rtl/bpli_line_if.sv]
// Backplane pulse line interface: pulse encoder, driver, strap, aux clock

// What this block does
// - Backplane one is a 1.6 us low pulse
// - Zero bit sends no pulse at all
// - Received low pulse is one, none zero
// - Driver select picks push-pull or open-drain
// - Open-drain driver after reset until the strap is captured, then driver select
// - Aux pin carries bit clock in backplane unless strapped to ground
// - Differential mode pulses only with enable asserted
// - Reset holds all line outputs inactive
// - Aux pin strap sets enable polarity
// - Strapped polarity applies in backplane mode only
module bpli_line_if (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // Configuration
    input  bpli_pkg::bpli_cfg_t    cfgIn,
    // Transmit bit stream
    input  wire logic              txValid,
    input  wire logic              txBit,
    output logic                   txReady,
    // Received bit stream
    output bpli_pkg::bpli_rx_t     rxOut,
    // Line pulse pin
    output logic                   linePulseOut,
    output logic                   linePulseOe,
    // Aux pulse clock pin, also the polarity strap
    input  wire logic              auxPulseIn,
    output logic                   auxPulseClockOut,
    output logic                   auxPulseOe,
    // Transceiver enable and line receive
    output logic                   transmitEnableOut,
    input  wire logic              lineReceiveIn,
    // Status
    output logic                   strapActiveHigh
);

    typedef enum logic {
        TX_IDLE,
        TX_SEND
    } bpli_tx_state_t;

    // ------------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------------
    logic                          auxSync1_ff;
    logic                          auxSync2_ff;
    logic [1:0]                    strapCnt_ff, nxt_strapCnt;
    logic                          strapDone_ff, nxt_strapDone;
    logic                          strapHigh_ff, nxt_strapHigh;
    logic                          pushPull_ff, nxt_pushPull;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            auxSync1_ff <= 1'h1;
            auxSync2_ff <= 1'h1;
        end else begin
            auxSync1_ff <= auxPulseIn;
            auxSync2_ff <= auxSync1_ff;
        end
    end

    always_comb begin
        nxt_strapCnt  = strapCnt_ff;
        nxt_strapDone = strapDone_ff;
        nxt_strapHigh = strapHigh_ff;
        nxt_pushPull  = cfgIn.driverSelectBit;
        if (!strapDone_ff) begin
            nxt_pushPull = bpli_pkg::RST_PUSH_PULL;
            if (strapCnt_ff == bpli_pkg::STRAP_WAIT) begin
                nxt_strapDone = 1'h1;
                nxt_strapHigh = ~auxSync2_ff;
            end else begin
                nxt_strapCnt = strapCnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strapCnt_ff  <= '0;
            strapDone_ff <= 1'h0;
            strapHigh_ff <= bpli_pkg::RST_STRAP_HIGH;
            pushPull_ff  <= bpli_pkg::RST_PUSH_PULL;
        end else begin
            strapCnt_ff  <= nxt_strapCnt;
            strapDone_ff <= nxt_strapDone;
            strapHigh_ff <= nxt_strapHigh;
            pushPull_ff  <= nxt_pushPull;
        end
    end

    // ------------------------------------------------------------------
    // Transmit encoder
    // ------------------------------------------------------------------
    bpli_tx_state_t                txState_ff, nxt_txState;
    logic [bpli_pkg::CNT_W-1:0]    txCnt_ff, nxt_txCnt;
    logic                          txBit_ff, nxt_txBit;
    logic                          lastCycle;
    logic                          canSend;
    logic                          take;
    logic                          pulse;
    logic                          txActive;

    assign lastCycle = (txCnt_ff == bpli_pkg::BIT_CYCLES - bpli_pkg::CNT_W'(1));
    assign canSend   = strapDone_ff & cfgIn.backplane;
    assign txReady   = canSend & ((txState_ff == TX_IDLE) | lastCycle);
    assign take      = txReady & txValid;

    always_comb begin
        nxt_txState = txState_ff;
        nxt_txCnt   = txCnt_ff;
        nxt_txBit   = txBit_ff;
        case (txState_ff)
            TX_IDLE: begin
                nxt_txCnt = '0;
                if (take) begin
                    nxt_txState = TX_SEND;
                    nxt_txBit   = txBit;
                end
            end
            TX_SEND: begin
                if (!cfgIn.backplane) begin
                    nxt_txState = TX_IDLE;
                    nxt_txCnt   = '0;
                end else if (lastCycle) begin
                    nxt_txCnt = '0;
                    if (take) begin
                        nxt_txBit = txBit;
                    end else begin
                        nxt_txState = TX_IDLE;
                    end
                end else begin
                    nxt_txCnt = txCnt_ff + bpli_pkg::CNT_W'(1);
                end
            end
            default: begin
                nxt_txState = TX_IDLE;
                nxt_txCnt   = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txState_ff <= TX_IDLE;
            txCnt_ff   <= '0;
            txBit_ff   <= 1'h0;
        end else begin
            txState_ff <= nxt_txState;
            txCnt_ff   <= nxt_txCnt;
            txBit_ff   <= nxt_txBit;
        end
    end

    // Enable and pulse derive from the same next state, so they share an edge
    assign txActive = (nxt_txState == TX_SEND);
    assign pulse    = txActive & nxt_txBit & (nxt_txCnt < bpli_pkg::PULSE_CYCLES);

    // ------------------------------------------------------------------
    // Aux bit clock
    // ------------------------------------------------------------------
    logic [bpli_pkg::CNT_W-1:0]    auxCnt_ff, nxt_auxCnt;

    always_comb begin
        nxt_auxCnt = '0;
        if (canSend) begin
            nxt_auxCnt = (auxCnt_ff == bpli_pkg::BIT_CYCLES - bpli_pkg::CNT_W'(1)) ?
                         '0 : auxCnt_ff + bpli_pkg::CNT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------------
    logic                          pulseOut_ff, nxt_pulseOut;
    logic                          pulseOe_ff, nxt_pulseOe;
    logic                          auxOut_ff, nxt_auxOut;
    logic                          auxOe_ff, nxt_auxOe;
    logic                          drive_enable_pin_ff, nxt_drive_enable_pin;
    logic                          gatedPulse;

    // Differential mode only pulses while the transceiver is enabled
    assign gatedPulse = pulse & (txActive | ~cfgIn.diffDriver);

    always_comb begin
        // Push-pull drives always; open-drain only pulls low
        if (pushPull_ff) begin
            nxt_pulseOut = ~gatedPulse;
            nxt_pulseOe  = strapDone_ff;
        end else begin
            nxt_pulseOut = 1'h0;
            nxt_pulseOe  = gatedPulse;
        end
        // Aux clock idles released; never driven into a grounded strap
        nxt_auxOe  = canSend & ~strapHigh_ff;
        nxt_auxOut = (nxt_auxCnt < bpli_pkg::AUX_HALF_CYCLES);
        if (cfgIn.backplane && strapHigh_ff) begin
            nxt_drive_enable_pin = txActive;
        end else begin
            nxt_drive_enable_pin = ~txActive;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pulseOut_ff <= 1'h1;
            pulseOe_ff  <= 1'h0;
            auxOut_ff   <= 1'h1;
            auxOe_ff    <= 1'h0;
            drive_enable_pin_ff     <= 1'h1;
            auxCnt_ff   <= '0;
        end else begin
            pulseOut_ff <= nxt_pulseOut;
            pulseOe_ff  <= nxt_pulseOe;
            auxOut_ff   <= nxt_auxOut;
            auxOe_ff    <= nxt_auxOe;
            drive_enable_pin_ff     <= nxt_drive_enable_pin;
            auxCnt_ff   <= nxt_auxCnt;
        end
    end

    assign linePulseOut      = pulseOut_ff;
    assign linePulseOe       = pulseOe_ff;
    assign auxPulseClockOut  = auxOut_ff;
    assign auxPulseOe        = auxOe_ff;
    assign transmitEnableOut = drive_enable_pin_ff;
    assign strapActiveHigh   = strapHigh_ff;

    // ------------------------------------------------------------------
    // Receive decoder
    // ------------------------------------------------------------------
    bpli_rx_decoder u_rx (
        .clock  (clock),
        .rstn   (rstn),
        .lineIn (lineReceiveIn),
        .enable (cfgIn.backplane),
        .rxOut  (rxOut)
    );

endmodule

// [rtl/bpli_pkg.sv]
// Constants and carrier types for the backplane pulse line interface
package bpli_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_PS  = 4000;
    localparam int          PULSE_TIME_NS  = 1600;
    localparam int          BIT_TIME_NS    = 3200;
    localparam int          CNT_W          = 10;
    localparam logic [CNT_W-1:0] PULSE_CYCLES =
        CNT_W'((PULSE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] BIT_CYCLES   =
        CNT_W'((BIT_TIME_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [CNT_W-1:0] AUX_HALF_CYCLES = CNT_W'(BIT_CYCLES / 2);

    // ------------------------------------------------------------------
    // Receive and strap settings
    // ------------------------------------------------------------------
    localparam logic [3:0]  RX_IDLE_BITS   = 4'h8;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic        RST_PUSH_PULL  = 1'h0;
    localparam logic        RST_STRAP_HIGH = 1'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic backplane;
        logic diffDriver;
        logic driverSelectBit;
    } bpli_cfg_t;

    typedef struct packed {
        logic valid;
        logic bitVal;
    } bpli_rx_t;

endpackage

// [rtl/bpli_rx_decoder.sv]
// Receive pulse decoder: synchroniser, falling edge detect, bit windows
module bpli_rx_decoder (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // Line and control
    input  wire logic              lineIn,
    input  wire logic              enable,
    // Decoded bits
    output bpli_pkg::bpli_rx_t     rxOut
);

    // ------------------------------------------------------------------
    // Synchroniser and edge detect
    // ------------------------------------------------------------------
    logic                          sync1_ff;
    logic                          sync2_ff;
    logic                          prev_ff;
    logic                          fall;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= 1'h1;
            sync2_ff <= 1'h1;
            prev_ff  <= 1'h1;
        end else begin
            sync1_ff <= lineIn;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign fall = prev_ff & ~sync2_ff;

    // ------------------------------------------------------------------
    // Bit window
    // ------------------------------------------------------------------
    logic                          active_ff, nxt_active;
    logic                          seen_ff, nxt_seen;
    logic [bpli_pkg::CNT_W-1:0]    cnt_ff, nxt_cnt;
    logic [3:0]                    zeros_ff, nxt_zeros;
    bpli_pkg::bpli_rx_t            rx_ff, nxt_rx;

    always_comb begin
        nxt_active   = active_ff;
        nxt_seen     = seen_ff;
        nxt_cnt      = cnt_ff;
        nxt_zeros    = zeros_ff;
        nxt_rx.valid = 1'h0;
        nxt_rx.bitVal = rx_ff.bitVal;
        if (!enable) begin
            nxt_active = 1'h0;
            nxt_seen   = 1'h0;
            nxt_cnt    = '0;
            nxt_zeros  = '0;
        end else if (!active_ff) begin
            if (fall) begin
                nxt_active = 1'h1;
                nxt_seen   = 1'h1;
                nxt_cnt    = bpli_pkg::CNT_W'(1);
                nxt_zeros  = '0;
            end
        end else if (cnt_ff == bpli_pkg::BIT_CYCLES - bpli_pkg::CNT_W'(1)) begin
            // Pulse in window is a one, no pulse a zero
            nxt_rx.valid  = 1'h1;
            nxt_rx.bitVal = seen_ff;
            nxt_cnt       = '0;
            nxt_seen      = fall;
            nxt_zeros     = seen_ff ? 4'h0 : zeros_ff + 4'h1;
            if (!seen_ff && !fall && (zeros_ff + 4'h1 >= bpli_pkg::RX_IDLE_BITS)) begin
                nxt_active = 1'h0;
            end
        end else begin
            nxt_cnt  = cnt_ff + bpli_pkg::CNT_W'(1);
            nxt_seen = seen_ff | fall;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            active_ff <= 1'h0;
            seen_ff   <= 1'h0;
            cnt_ff    <= '0;
            zeros_ff  <= '0;
            rx_ff     <= '0;
        end else begin
            active_ff <= nxt_active;
            seen_ff   <= nxt_seen;
            cnt_ff    <= nxt_cnt;
            zeros_ff  <= nxt_zeros;
            rx_ff     <= nxt_rx;
        end
    end

    assign rxOut = rx_ff;

endmodule

// [testbench/bpli_line_if_chk.sv]
// Assertion checker for the backplane pulse line interface
module bpli_line_if_chk (
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           rstn,
    // Configuration and transmit stream
    input  bpli_pkg::bpli_cfg_t cfgIn,
    input  wire logic           txValid,
    input  wire logic           txBit,
    input  wire logic           txReady,
    // Receive stream and pins
    input  bpli_pkg::bpli_rx_t  rxOut,
    input  wire logic           linePulseOut,
    input  wire logic           linePulseOe,
    input  wire logic           auxPulseIn,
    input  wire logic           auxPulseClockOut,
    input  wire logic           auxPulseOe,
    input  wire logic           transmitEnableOut,
    input  wire logic           lineReceiveIn,
    input  wire logic           strapActiveHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // Run counters
    // ------------------------------------------------------------------
    logic        lineLow;
    logic [9:0]  lowRun_ff;
    logic [9:0]  auxLow_ff;
    logic [10:0] age_ff;
    logic        rstSeen_ff;
    assign lineLow = linePulseOe && !linePulseOut;
    // Reset seen at the previous edge too, so registers have settled
    always_ff @(posedge clock) begin
        rstSeen_ff <= !rstn;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lowRun_ff <= 10'h0;
            auxLow_ff <= 10'h0;
            age_ff    <= 11'h7FF;
        end else begin
            lowRun_ff <= lineLow ? lowRun_ff + 10'h1 : 10'h0;
            auxLow_ff <= auxPulseClockOut ? 10'h0 : auxLow_ff + 10'h1;
            // Cycles since the line last fell, saturating
            age_ff    <= $fell(lineReceiveIn) ? 11'h0 :
                         (age_ff == 11'h7FF) ? age_ff : age_ff + 11'h1;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_take;
        txValid && txReady && cfgIn.backplane;
    endsequence
    sequence s_lowEnd;
        $past(lineLow) && !lineLow;
    endsequence
    property p_oneWidth;
        s_lowEnd |-> lowRun_ff == bpli_pkg::PULSE_CYCLES;
    endproperty
    property p_zero;
        s_take ##0 !txBit |=> (!lineLow)[*8];
    endproperty
    property p_rxBit;
        rxOut.valid |-> rxOut.bitVal ==
            ($past(age_ff, 200) >= 11'h0C8 && $past(age_ff, 200) < 11'h3E8);
    endproperty
    property p_openDrain;
        (!cfgIn.driverSelectBit)[*3] |-> !(linePulseOe && linePulseOut);
    endproperty
    property p_pushPull;
        (cfgIn.driverSelectBit && txReady)[*3] |-> linePulseOe;
    endproperty
    property p_auxClock;
        auxPulseOe && $rose(auxPulseClockOut) |-> auxLow_ff == bpli_pkg::AUX_HALF_CYCLES;
    endproperty
    property p_enGate;
        cfgIn.diffDriver && lineLow |-> transmitEnableOut == strapActiveHigh;
    endproperty
    property p_reset;
        disable iff (1'b0)
        !rstn && rstSeen_ff |->
            !linePulseOe && !auxPulseOe && transmitEnableOut && !txReady && !rxOut.valid;
    endproperty
    property p_normalPol;
        (!cfgIn.backplane)[*2] |-> transmitEnableOut && !txReady;
    endproperty
    property p_strapAux;
        strapActiveHigh |-> !auxPulseOe;
    endproperty
    property p_take;
        s_take |=> (!txReady)[*8];
    endproperty
    a_oneWidth: assert property (p_oneWidth) else $error("pulse width wrong");
    a_zero: assert property (p_zero) else $error("pulse on zero bit");
    a_rxBit: assert property (p_rxBit) else $error("decoded bit wrong");
    a_openDrain: assert property (p_openDrain) else $error("drove high");
    a_pushPull: assert property (p_pushPull) else $error("not driving");
    a_auxClock: assert property (p_auxClock) else $error("aux clock period");
    a_enGate: assert property (p_enGate) else $error("pulse without enable");
    a_reset: assert property (p_reset) else $error("active in reset");
    a_normalPol: assert property (p_normalPol) else $error("enable polarity");
    a_strapAux: assert property (p_strapAux) else $error("aux driven on strap");
    a_take: assert property (p_take) else $error("bit taken early");
endmodule

bind bpli_line_if bpli_line_if_chk u_chk (.clock, .rstn, .cfgIn, .txValid, .txBit, .txReady,
    .rxOut, .linePulseOut, .linePulseOe, .auxPulseIn, .auxPulseClockOut, .auxPulseOe,
    .transmitEnableOut, .lineReceiveIn, .strapActiveHigh);

// [testbench/bpli_line_model.sv]
// Partner model: pulled-up backplane wire and the strap on the aux pin
module bpli_line_model (
    // Device pins
    input  wire logic linePulseOut,
    input  wire logic linePulseOe,
    input  wire logic auxPulseClockOut,
    input  wire logic auxPulseOe,
    // Strap choice
    input  wire logic strapGnd,
    // Levels seen by the device
    output logic      lineLevel,
    output logic      auxLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wire rests high on its pull-up unless pulled low
    assign lineLevel = (linePulseOe && !linePulseOut) ? 1'b0 : 1'b1;
    // Ground strap held for the whole run, not only at reset
    assign auxLevel = strapGnd ? 1'b0 : (auxPulseOe ? auxPulseClockOut : 1'b1);
endmodule

// [testbench/bpli_line_if_tb.sv]
// Self-checking bench for the backplane pulse line interface
module bpli_line_if_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clock;
    logic                rstn;
    bpli_pkg::bpli_cfg_t cfgIn;
    logic                txValid;
    logic                txBit;
    logic                txReady;
    bpli_pkg::bpli_rx_t  rxOut;
    logic                linePulseOut;
    logic                linePulseOe;
    logic                auxPulseIn;
    logic                auxPulseClockOut;
    logic                auxPulseOe;
    logic                transmitEnableOut;
    logic                lineReceiveIn;
    logic                strapActiveHigh;
    logic                strapGnd;
    int                  bad_count;
    int                  n_compared;
    int                  seed;
    int                  cycles;
    int                  lowCnt;
    int                  lowQ[$];
    logic                rxQ[$];
    logic                auxLast;
    int                  auxRun;
    int                  auxQ[$];

    bpli_line_if dut (.clock, .rstn, .cfgIn, .txValid, .txBit, .txReady, .rxOut,
        .linePulseOut, .linePulseOe, .auxPulseIn, .auxPulseClockOut, .auxPulseOe,
        .transmitEnableOut, .lineReceiveIn, .strapActiveHigh);
    bpli_line_model u_line (.linePulseOut, .linePulseOe, .auxPulseClockOut, .auxPulseOe,
        .strapGnd, .lineLevel(lineReceiveIn), .auxLevel(auxPulseIn));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // Line and receive monitors, run limit
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        cycles++;
        if (!lineReceiveIn)
            lowCnt++;
        else if (lowCnt > 0) begin
            lowQ.push_back(lowCnt);
            lowCnt = 0;
        end
        if (rxOut.valid === 1'b1)
            rxQ.push_back(rxOut.bitVal);
        // Aux clock level run lengths while driven
        if (auxPulseOe === 1'b1 && auxPulseClockOut !== auxLast) begin
            auxQ.push_back(auxRun);
            auxRun = 0;
        end
        auxLast = auxPulseClockOut;
        auxRun++;
        if (cycles == 90000) begin
            bad_count++;
            end_sim();
        end
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic doReset();
        rstn <= 1'b0;
        repeat (16) @(posedge clock);
        chk("reset line oe", 16'h0, 16'(linePulseOe));
        chk("reset aux oe", 16'h0, 16'(auxPulseOe));
        chk("reset enable", 16'h1, 16'(transmitEnableOut));
        chk("reset ready", 16'h0, 16'(txReady));
        rstn <= 1'b1;
        repeat (10) @(posedge clock);
        chk("strap", {15'h0, strapGnd}, 16'(strapActiveHigh));
        chk("idle enable", {15'h0, ~strapGnd}, 16'(transmitEnableOut));
        chk("aux oe", {15'h0, ~strapGnd}, 16'(auxPulseOe));
        chk("idle line oe", 16'h0, 16'(linePulseOe));
    endtask

    // Sends n random bits, the first a one, then checks wire and decoder
    task automatic runBits(input int n);
        logic sent[$];
        int   ones;
        int   idle;
        int   tries;
        lowQ.delete();
        rxQ.delete();
        ones = 0;
        idle = 0;
        for (int i = 0; i < n; i++)
            sent.push_back(i == 0 ? 1'b1 : 1'($random(seed)));
        foreach (sent[i]) begin
            txValid <= 1'b1;
            txBit <= sent[i];
            tries = 0;
            do begin
                @(negedge clock);
                tries++;
            end while (txReady !== 1'b1 && tries < 1000);
            @(posedge clock);
        end
        txValid <= 1'b0;
        repeat ((n + 9) * 800 + 100) @(posedge clock);
        foreach (sent[i]) begin
            ones += sent[i];
            idle = sent[i] ? 0 : idle + 1;
        end
        chk("pulse count", 16'(ones), 16'(lowQ.size()));
        foreach (lowQ[i])
            chk("pulse width", 16'(bpli_pkg::PULSE_CYCLES), 16'(lowQ[i]));
        repeat (int'(bpli_pkg::RX_IDLE_BITS) - idle) sent.push_back(1'b0);
        chk("rx count", 16'(sent.size()), 16'(rxQ.size()));
        foreach (sent[i])
            chk("rx bit", {15'h0, sent[i]}, {15'h0, rxQ[i]});
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 97;
        rstn = 1'b0;
        cfgIn = 3'h4;
        txValid = 1'b0;
        txBit = 1'b0;
        strapGnd = 1'b0;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        lowCnt = 0;
        doReset();
        for (int m = 0; m < 4; m++) begin
            cfgIn <= {1'b1, m[1], m[0]};
            repeat (4) @(posedge clock);
            chk("idle drive", {15'h0, m[0]}, 16'(linePulseOe));
            runBits(5);
        end
        for (int i = 1; i < 4; i++)
            chk("aux half period", 16'(bpli_pkg::AUX_HALF_CYCLES), 16'(auxQ[i]));
        lowQ.delete();
        cfgIn <= 3'h0;
        txValid <= 1'b1;
        repeat (20) @(posedge clock);
        chk("ready off", 16'h0, 16'(txReady));
        chk("enable off", 16'h1, 16'(transmitEnableOut));
        chk("no pulses", 16'h0, 16'(lowQ.size()));
        txValid <= 1'b0;
        cfgIn <= 3'h6;
        strapGnd <= 1'b1;
        doReset();
        runBits(4);
        chk("idle enable high", 16'h0, 16'(transmitEnableOut));
        cfgIn <= 3'h2;
        repeat (4) @(posedge clock);
        chk("strap outside mode", 16'h1, 16'(transmitEnableOut));
        end_sim();
    end
endmodule
